/* hdl/pao_pkg.sv */
// Constants shared by the phase accumulator oscillator: register map, fields, reset values.
// Assumes a 32-bit APB register bus with byte addresses and one word per register.
package pao_pkg;

  // Register byte offsets
  localparam logic [7:0] PAO_OFS_CTRL     = 8'h00;
  localparam logic [7:0] PAO_OFS_CLK      = 8'h04;
  localparam logic [7:0] PAO_OFS_ACCL     = 8'h08;
  localparam logic [7:0] PAO_OFS_ACCH     = 8'h0C;
  localparam logic [7:0] PAO_OFS_INC      = 8'h10;
  localparam logic [7:0] PAO_OFS_IRQ_STAT = 8'h14;
  localparam logic [7:0] PAO_OFS_IRQ_MASK = 8'h18;
  localparam logic [7:0] PAO_OFS_IRQ_CTRL = 8'h1C;

  // Control register fields
  localparam int unsigned PAO_CTRL_ON_BIT  = 7;
  localparam int unsigned PAO_CTRL_OUT_BIT = 5;
  localparam int unsigned PAO_CTRL_POL_BIT = 4;
  localparam int unsigned PAO_CTRL_PFM_BIT = 0;

  // Clock register fields
  localparam int unsigned PAO_CLK_PWS_LSB = 5;
  localparam int unsigned PAO_CLK_CKS_LSB = 0;

  // Interrupt control fields
  localparam int unsigned PAO_IRQ_PERIPH_BIT = 0;
  localparam int unsigned PAO_IRQ_GLOBAL_BIT = 1;

  // Reset values
  localparam logic [7:0] PAO_RST_BYTE = 8'h00;
  localparam logic [1:0] PAO_RST_CKS  = 2'h0;
  localparam logic [2:0] PAO_RST_PWS  = 3'h0;

  // Clock source codes
  typedef enum logic [1:0] {
    PAO_CKS_FAST = 2'b00,
    PAO_CKS_SYS  = 2'b01,
    PAO_CKS_LC1  = 2'b10,
    PAO_CKS_RSVD = 2'b11
  } pao_cks_t;

  // Nominal fast internal oscillator rate in MHz
  localparam int unsigned PAO_FAST_OSC_MHZ = 16;

endpackage : pao_pkg

/* hdl/pao_sync.sv */
// Two-flop synchroniser for levels arriving from outside the I_CLK domain.
// Assumes each bit is an independent level; no multi-bit coherence.
`timescale 1ns/1ps
module pao_sync #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  // Data
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);

  logic [W-1:0] meta_ff;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      meta_ff <= '0;
      o_q     <= '0;
    end else begin
      meta_ff <= i_d;
      o_q     <= meta_ff;
    end
  end

endmodule : pao_sync

/* hdl/pao_pulse.sv */
// Pulse width timer: active for 2**width_sel input clock ticks after each start.
// Assumes start coincides with a tick; a new start restarts the count.
`timescale 1ns/1ps
module pao_pulse
  import pao_pkg::*;
(
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  // Control
  input  wire logic       i_clear,
  input  wire logic       i_start,
  input  wire logic       i_tick,
  input  wire logic [2:0] i_width_sel,
  // Status
  output logic            o_active
);

  localparam logic [7:0] ONE = 8'h01;

  logic [7:0] cnt_ff;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n || i_clear) begin
      cnt_ff   <= PAO_RST_BYTE;
      o_active <= 1'b0;
    end else if (i_start) begin
      // Restart holds the output active when width exceeds the period
      cnt_ff   <= ONE << i_width_sel;
      o_active <= 1'b1;
    end else if (i_tick && o_active) begin
      cnt_ff   <= cnt_ff - ONE;
      o_active <= (cnt_ff != ONE);
    end
  end

  a_width_load: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_start && !i_clear) |=> (o_active && cnt_ff == (ONE << $past(i_width_sel))))
    else $error("pulse width count not loaded from width select");

endmodule : pao_pulse

/* hdl/pao_top.sv */
// Phase accumulator oscillator with APB registers and a level interrupt.
// Assumes an APB master on I_CLK; clock source pins are asynchronous and slower than I_CLK.
`timescale 1ns/1ps
// Summary of operation
// - Each accumulator overflow sets the sticky overflow interrupt flag.
// - Interrupt asserts only with module on, mask, peripheral and global enables set.
// - Reset clears every control, clock select and accumulator register to zero.
// - Accumulation and output continue during sleep while the source runs.
// - Fast oscillator kept running in sleep when enabled and selected.
// - Polarity bit inverts the output signal while the module is on.
// - Mode bit selects pulse frequency mode, else divide-by-two square wave.
// - Pulse width lasts two to the field value input clock periods.
// - Width longer than overflow period holds the output without toggling.
// - Clock field picks fast oscillator, system clock, logic cell, or nothing.
// - Low accumulator byte readable and writable by software, resets to zero.
module pao_top
  import pao_pkg::*;
#(
  parameter int unsigned ACC_W = 20
) (
  // Clock and reset
  input  wire logic        I_CLK,
  input  wire logic        I_RST_N,
  // APB slave
  input  wire logic        I_PSEL,
  input  wire logic        I_PENABLE,
  input  wire logic        I_PWRITE,
  input  wire logic [7:0]  I_PADDR,
  input  wire logic [31:0] I_PWDATA,
  output logic      [31:0] O_PRDATA,
  output logic             O_PREADY,
  output logic             O_PSLVERR,
  // Clock sources and power state
  input  wire logic        I_FAST_OSC_CLK,
  input  wire logic        I_LOGIC_CELL_OUT,
  input  wire logic        I_SLEEP,
  // Outputs
  output logic             O_OSC_OUT,
  output logic             O_IRQ,
  output logic             O_FAST_OSC_KEEP
);

  localparam int unsigned HI_W = ACC_W - 8;

  // Register state
  logic             module_on_ff;
  logic             output_invert_ff;
  logic             pulse_freq_select_ff;
  logic [2:0]       pulse_width_select_ff;
  logic [1:0]       clock_source_select_ff;
  logic [ACC_W-1:0] phase_accumulator_ff;
  logic [ACC_W-1:0] increment_ff;
  logic             overflow_irq_flag_ff;
  logic             overflow_irq_enable_ff;
  logic             peripheral_irq_enable_ff;
  logic             global_irq_enable_ff;

  // Datapath state
  logic             square_ff;
  logic             fast_prev_ff;
  logic             lc_prev_ff;
  logic             output_state_ff;
  logic [31:0]      nxt_prdata;
  logic             nxt_slverr;
  logic             nxt_raw;

  // Bus decode
  logic apb_done;
  logic wr_en;
  logic rd_en;
  assign apb_done = I_PSEL && I_PENABLE && O_PREADY;
  assign wr_en    = apb_done && I_PWRITE;
  assign rd_en    = apb_done && !I_PWRITE;

  // Clock source synchronisation and edge detection
  logic [1:0] src_sync;
  logic       fast_rise;
  logic       lc_rise;
  logic       tick;

  pao_sync #(.W(2)) u_src_sync (
    .i_clk   (I_CLK),
    .i_rst_n (I_RST_N),
    .i_d     ({I_LOGIC_CELL_OUT, I_FAST_OSC_CLK}),
    .o_q     (src_sync)
  );

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      fast_prev_ff <= 1'b0;
      lc_prev_ff   <= 1'b0;
    end else begin
      fast_prev_ff <= src_sync[0];
      lc_prev_ff   <= src_sync[1];
    end
  end

  assign fast_rise = src_sync[0] && !fast_prev_ff;
  assign lc_rise   = src_sync[1] && !lc_prev_ff;

  always_comb begin
    unique case (pao_cks_t'(clock_source_select_ff))
      PAO_CKS_FAST: tick = fast_rise;
      PAO_CKS_SYS:  tick = 1'b1;
      PAO_CKS_LC1:  tick = lc_rise;
      PAO_CKS_RSVD: tick = 1'b0;
    endcase
  end

  // Accumulator; sleep does not gate it
  logic [ACC_W:0] acc_sum;
  logic           acc_step;
  logic           wrap_event;
  assign acc_sum    = {1'b0, phase_accumulator_ff} + {1'b0, increment_ff};
  assign acc_step   = module_on_ff && tick;
  assign wrap_event = acc_step && acc_sum[ACC_W];

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      phase_accumulator_ff <= '0;
    end else if (wr_en && I_PADDR == PAO_OFS_ACCL) begin
      phase_accumulator_ff[7:0] <= I_PWDATA[7:0];
    end else if (wr_en && I_PADDR == PAO_OFS_ACCH) begin
      phase_accumulator_ff[ACC_W-1:8] <= I_PWDATA[HI_W-1:0];
    end else if (acc_step) begin
      phase_accumulator_ff <= acc_sum[ACC_W-1:0];
    end
  end

  // Control and configuration registers
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      module_on_ff           <= 1'b0;
      output_invert_ff       <= 1'b0;
      pulse_freq_select_ff   <= 1'b0;
      pulse_width_select_ff  <= PAO_RST_PWS;
      clock_source_select_ff <= PAO_RST_CKS;
      increment_ff           <= '0;
    end else if (wr_en) begin
      unique case (I_PADDR)
        PAO_OFS_CTRL: begin
          module_on_ff         <= I_PWDATA[PAO_CTRL_ON_BIT];
          output_invert_ff     <= I_PWDATA[PAO_CTRL_POL_BIT];
          pulse_freq_select_ff <= I_PWDATA[PAO_CTRL_PFM_BIT];
        end
        PAO_OFS_CLK: begin
          pulse_width_select_ff  <= I_PWDATA[PAO_CLK_PWS_LSB +: 3];
          clock_source_select_ff <= I_PWDATA[PAO_CLK_CKS_LSB +: 2];
        end
        PAO_OFS_INC: begin
          increment_ff <= I_PWDATA[ACC_W-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Output generation
  logic pulse_active;
  pao_pulse u_pulse (
    .i_clk       (I_CLK),
    .i_rst_n     (I_RST_N),
    .i_clear     (!module_on_ff),
    .i_start     (wrap_event && pulse_freq_select_ff),
    .i_tick      (acc_step),
    .i_width_sel (pulse_width_select_ff),
    .o_active    (pulse_active)
  );

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N || !module_on_ff) begin
      square_ff <= 1'b0;
    end else if (wrap_event && !pulse_freq_select_ff) begin
      square_ff <= !square_ff;
    end
  end

  always_comb begin
    if (pulse_freq_select_ff) begin
      nxt_raw = pulse_active;
    end else begin
      nxt_raw = square_ff;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      output_state_ff <= 1'b0;
    end else begin
      output_state_ff <= module_on_ff && (nxt_raw ^ output_invert_ff);
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      O_OSC_OUT <= 1'b0;
    end else begin
      O_OSC_OUT <= module_on_ff && (nxt_raw ^ output_invert_ff);
    end
  end

  // Fast oscillator keep-alive request in sleep
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      O_FAST_OSC_KEEP <= 1'b0;
    end else begin
      O_FAST_OSC_KEEP <= I_SLEEP && module_on_ff
                         && (clock_source_select_ff == PAO_CKS_FAST);
    end
  end

  // Interrupt flag, mask and enables
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      overflow_irq_flag_ff <= 1'b0;
    end else if (wrap_event) begin
      overflow_irq_flag_ff <= 1'b1;
    end else if (rd_en && I_PADDR == PAO_OFS_IRQ_STAT) begin
      overflow_irq_flag_ff <= 1'b0;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      overflow_irq_enable_ff   <= 1'b0;
      peripheral_irq_enable_ff <= 1'b0;
      global_irq_enable_ff     <= 1'b0;
    end else if (wr_en && I_PADDR == PAO_OFS_IRQ_MASK) begin
      overflow_irq_enable_ff <= I_PWDATA[0];
    end else if (wr_en && I_PADDR == PAO_OFS_IRQ_CTRL) begin
      peripheral_irq_enable_ff <= I_PWDATA[PAO_IRQ_PERIPH_BIT];
      global_irq_enable_ff     <= I_PWDATA[PAO_IRQ_GLOBAL_BIT];
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      O_IRQ <= 1'b0;
    end else begin
      O_IRQ <= overflow_irq_flag_ff && overflow_irq_enable_ff && module_on_ff
               && peripheral_irq_enable_ff && global_irq_enable_ff;
    end
  end

  // APB read mux and answer
  always_comb begin
    nxt_prdata = 32'h0000_0000;
    nxt_slverr = 1'b0;
    unique case (I_PADDR)
      PAO_OFS_CTRL: begin
        nxt_prdata[PAO_CTRL_ON_BIT]  = module_on_ff;
        nxt_prdata[PAO_CTRL_OUT_BIT] = output_state_ff;
        nxt_prdata[PAO_CTRL_POL_BIT] = output_invert_ff;
        nxt_prdata[PAO_CTRL_PFM_BIT] = pulse_freq_select_ff;
      end
      PAO_OFS_CLK: begin
        nxt_prdata[PAO_CLK_PWS_LSB +: 3] = pulse_width_select_ff;
        nxt_prdata[PAO_CLK_CKS_LSB +: 2] = clock_source_select_ff;
      end
      PAO_OFS_ACCL:     nxt_prdata[7:0]       = phase_accumulator_ff[7:0];
      PAO_OFS_ACCH:     nxt_prdata[HI_W-1:0]  = phase_accumulator_ff[ACC_W-1:8];
      PAO_OFS_INC:      nxt_prdata[ACC_W-1:0] = increment_ff;
      PAO_OFS_IRQ_STAT: nxt_prdata[0]         = overflow_irq_flag_ff;
      PAO_OFS_IRQ_MASK: nxt_prdata[0]         = overflow_irq_enable_ff;
      PAO_OFS_IRQ_CTRL: begin
        nxt_prdata[PAO_IRQ_PERIPH_BIT] = peripheral_irq_enable_ff;
        nxt_prdata[PAO_IRQ_GLOBAL_BIT] = global_irq_enable_ff;
      end
      default: nxt_slverr = 1'b1;
    endcase
  end

  // One wait state: pready rises in the second access cycle
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      O_PREADY  <= 1'b0;
      O_PRDATA  <= 32'h0000_0000;
      O_PSLVERR <= 1'b0;
    end else begin
      O_PREADY  <= I_PSEL && I_PENABLE && !O_PREADY;
      O_PSLVERR <= I_PSEL && I_PENABLE && !O_PREADY && nxt_slverr;
      if (I_PSEL && I_PENABLE && !O_PREADY && !I_PWRITE) begin
        O_PRDATA <= nxt_prdata;
      end else begin
        O_PRDATA <= 32'h0000_0000;
      end
    end
  end

  // Checks
  a_flag_on_wrap: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    wrap_event |=> overflow_irq_flag_ff)
    else $error("overflow did not set the interrupt flag");

  a_flag_clear: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    (rd_en && I_PADDR == PAO_OFS_IRQ_STAT && !wrap_event) |=> !overflow_irq_flag_ff)
    else $error("status read did not clear the flag");

  a_irq_gating: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    O_IRQ |-> $past(overflow_irq_flag_ff && overflow_irq_enable_ff && module_on_ff
                    && peripheral_irq_enable_ff && global_irq_enable_ff))
    else $error("interrupt raised without all enables set");

  a_reset_clears: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    $rose(I_RST_N) |-> (!module_on_ff && phase_accumulator_ff == '0
                        && clock_source_select_ff == PAO_RST_CKS))
    else $error("registers not cleared by reset");

  a_acc_advance: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    (acc_step && !wr_en) |=> phase_accumulator_ff == $past(acc_sum[ACC_W-1:0]))
    else $error("accumulator did not add the increment");

  a_fast_keep: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    (I_SLEEP && module_on_ff && clock_source_select_ff == PAO_CKS_FAST) |=> O_FAST_OSC_KEEP)
    else $error("fast oscillator released during sleep");

  a_off_quiet: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    !module_on_ff |=> !O_OSC_OUT)
    else $error("output active while module is off");

  a_status_bit: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    (rd_en && I_PADDR == PAO_OFS_CTRL) |-> O_PRDATA[PAO_CTRL_OUT_BIT] == $past(output_state_ff))
    else $error("status bit does not show the output");

  a_polarity: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    module_on_ff |=> O_OSC_OUT == ($past(nxt_raw) ^ $past(output_invert_ff)))
    else $error("output polarity wrong");

  a_square_toggle: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    (wrap_event && !pulse_freq_select_ff) |=> square_ff != $past(square_ff))
    else $error("square wave did not toggle on overflow");

  a_pulse_active: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    (wrap_event && pulse_freq_select_ff) |=> ##1 (O_OSC_OUT != output_invert_ff || !module_on_ff))
    else $error("pulse not active after overflow");

endmodule : pao_top

/* testbench/test_pao_top.sv */
// Self-checking bench for the phase accumulator oscillator top level.
// Drives APB and the clock-source pins directly; one 10 MHz clock, no partner model.
`timescale 1ns/1ps
module test_pao_top
  import pao_pkg::*;
();
  logic        clk    = 1'b0;
  logic        rst_n  = 1'b0;
  logic        psel   = 1'b0;
  logic        pen    = 1'b0;
  logic        pwr    = 1'b0;
  logic [7:0]  paddr  = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic        fast   = 1'b0;
  logic        lcell  = 1'b0;
  logic        sleep  = 1'b0;
  logic [3:0]  div    = 4'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        osc;
  logic        irq;
  logic        keep;
  int          n_errors     = 0;
  int          total_checks = 0;
  int          cyc          = 0;

  pao_top #(.ACC_W(20)) u_pao_top (
    .I_CLK(clk), .I_RST_N(rst_n), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
    .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
    .O_PSLVERR(pslverr), .I_FAST_OSC_CLK(fast), .I_LOGIC_CELL_OUT(lcell),
    .I_SLEEP(sleep), .O_OSC_OUT(osc), .O_IRQ(irq), .O_FAST_OSC_KEEP(keep)
  );

  always #50 clk = ~clk;

  // Slow source clocks: fast oscillator at clk/4, logic cell at clk/8
  always @(posedge clk) begin
    div   <= div + 4'h1;
    fast  <= div[1];
    lcell <= div[2];
    cyc   <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // One APB transfer; holds the request until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1; pen <= 1'b0; pwr <= wr; paddr <= a; pwdata <= wd;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) chk("pready", 32'h0, 32'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; pen <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(what, r, exp);
  endtask : rdc

  task automatic settle(input int n);
    repeat (n) @(negedge clk);
  endtask : settle

  // High time and period of the next full output pulse, in clk cycles
  task automatic edge_gap(output int hi, output int per);
    int n;
    n = 0; hi = 0; per = 0;
    @(negedge clk);
    while (osc !== 1'b0 && n < 300) begin @(negedge clk); n++; end
    while (osc !== 1'b1 && n < 600) begin @(negedge clk); n++; end
    while (osc === 1'b1 && per < 300) begin @(negedge clk); hi++; per++; end
    while (osc !== 1'b1 && per < 300) begin @(negedge clk); per++; end
  endtask : edge_gap

  task automatic count_tog(input int cycles, output int n);
    logic p;
    n = 0;
    @(negedge clk);
    p = osc;
    repeat (cycles) begin
      @(negedge clk);
      if (osc !== p) n++;
      p = osc;
    end
  endtask : count_tog

  task automatic t_reset();
    logic [7:0] ofs [8] = '{PAO_OFS_CTRL, PAO_OFS_CLK, PAO_OFS_ACCL, PAO_OFS_ACCH,
                            PAO_OFS_INC, PAO_OFS_IRQ_STAT, PAO_OFS_IRQ_MASK, PAO_OFS_IRQ_CTRL};
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    settle(1);
    chk("osc after reset", {31'h0, osc}, 32'h0);
    chk("irq after reset", {31'h0, irq}, 32'h0);
    foreach (ofs[i]) rdc("reset value", ofs[i], 32'h0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_regs();
    logic [31:0] r;
    logic        e;
    wr(PAO_OFS_CTRL, 32'h0000_006E);
    rdc("ctrl reserved", PAO_OFS_CTRL, 32'h0);
    wr(PAO_OFS_CLK, 32'h0000_001C);
    rdc("clk reserved", PAO_OFS_CLK, 32'h0);
    wr(PAO_OFS_ACCL, 32'h0000_00A5);
    rdc("acc low", PAO_OFS_ACCL, 32'h0000_00A5);
    apb(1'b0, 8'h20, 32'h0, r, e);
    chk("unmapped err", {31'h0, e}, 32'h1);
    chk("unmapped data", r, 32'h0);
    $display("test registers done");
  endtask : t_regs

  task automatic t_square();
    int hi;
    int per;
    wr(PAO_OFS_INC, 32'h0008_0000);
    wr(PAO_OFS_CLK, 32'h0000_00E1);
    wr(PAO_OFS_CTRL, 32'h0000_0080);
    edge_gap(hi, per);
    chk("square period", per, 32'd4);
    chk("square high", hi, 32'd2);
    wr(PAO_OFS_CTRL, 32'h0);
    settle(2);
    chk("off output", {31'h0, osc}, 32'h0);
    wr(PAO_OFS_INC, 32'h0);
    wr(PAO_OFS_CTRL, 32'h0000_0080);
    rdc("state plain", PAO_OFS_CTRL, 32'h0000_0080);
    wr(PAO_OFS_CTRL, 32'h0000_0090);
    settle(2);
    chk("inverted out", {31'h0, osc}, 32'h1);
    rdc("state inverted", PAO_OFS_CTRL, 32'h0000_00B0);
    wr(PAO_OFS_CTRL, 32'h0000_0010);
    settle(2);
    chk("off inverted", {31'h0, osc}, 32'h0);
    $display("test square done");
  endtask : t_square

  task automatic t_pulse();
    int hi;
    int per;
    int low;
    wr(PAO_OFS_INC, 32'h0000_4000);
    wr(PAO_OFS_CTRL, 32'h0000_0081);
    for (int w = 0; w < 6; w++) begin
      wr(PAO_OFS_CLK, (w << PAO_CLK_PWS_LSB) | 32'h1);
      // First pulse may have been loaded with the old width
      edge_gap(hi, per);
      edge_gap(hi, per);
      chk("pulse width", hi, 32'd1 << w);
      chk("pulse period", per, 32'd64);
    end
    wr(PAO_OFS_CLK, 32'h0000_00E1);
    settle(140);
    low = 0;
    repeat (150) begin
      @(negedge clk);
      if (osc !== 1'b1) low++;
    end
    chk("wide pulse held", low, 32'd0);
    $display("test pulse done");
  endtask : t_pulse

  task automatic t_sources();
    int n;
    @(posedge clk);
    sleep <= 1'b1;
    wr(PAO_OFS_INC, 32'h0008_0000);
    wr(PAO_OFS_CTRL, 32'h0000_0080);
    for (int s = 0; s < 4; s++) begin
      wr(PAO_OFS_CLK, s);
      settle(3);
      chk("keep fast osc", {31'h0, keep}, {31'h0, s == 0});
      count_tog(80, n);
      chk("runs in sleep", {31'h0, n > 0}, {31'h0, s != 3});
    end
    wr(PAO_OFS_CLK, 32'h0);
    wr(PAO_OFS_CTRL, 32'h0);
    settle(3);
    chk("keep when off", {31'h0, keep}, 32'h0);
    @(posedge clk);
    sleep <= 1'b0;
    $display("test sources done");
  endtask : t_sources

  task automatic t_irq();
    logic [3:0] tbl [6] = '{4'hF, 4'h7, 4'hD, 4'hB, 4'hE, 4'hF};
    rdc("flag left set", PAO_OFS_IRQ_STAT, 32'h1);
    rdc("flag clear", PAO_OFS_IRQ_STAT, 32'h0);
    wr(PAO_OFS_CLK, 32'h1);
    wr(PAO_OFS_INC, 32'h0008_0000);
    wr(PAO_OFS_CTRL, 32'h0000_0080);
    wr(PAO_OFS_INC, 32'h0);
    // Row bits: mask, global, peripheral, module on; all four needed for the request
    foreach (tbl[i]) begin
      wr(PAO_OFS_IRQ_MASK, tbl[i][3]);
      wr(PAO_OFS_IRQ_CTRL, tbl[i][2:1]);
      wr(PAO_OFS_CTRL, tbl[i][0] ? 32'h0000_0080 : 32'h0);
      settle(3);
      chk("irq level", {31'h0, irq}, {31'h0, &tbl[i]});
    end
    rdc("flag set", PAO_OFS_IRQ_STAT, 32'h1);
    rdc("flag cleared", PAO_OFS_IRQ_STAT, 32'h0);
    settle(3);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    wr(PAO_OFS_INC, 32'h0000_1234);
    $display("test irq done");
  endtask : t_irq

  initial begin
    t_reset();
    t_regs();
    t_square();
    t_pulse();
    t_sources();
    t_irq();
    t_reset();
    stop_test();
  end
endmodule : test_pao_top
